// >>> rtl/vc_map_cfg.svh
`ifndef VC_MAP_CFG_SVH
`define VC_MAP_CFG_SVH

// ==========================================================================
// Register map
`define ADDR_W           12
`define REG_CHIP_MODE    12'h200
`define REG_OUT_FORMAT   12'h561
`define REG_LANE_RATE    12'h56E
`define REG_PLL_STATUS   12'h56F
`define REG_LINK_CTRL    12'h5B0
`define REG_DEEMPH_EN    12'h5C1
`define REG_DEEMPH_LVL   12'h5C5

// ==========================================================================
// Field positions
`define MODE_MSB         1
`define MODE_LSB         0
`define QIGN_BIT         5
`define FMT_BIT          0
`define LOW_RATE_BIT     4
`define PLL_LOCK_BIT     7
`define LINK_EN_BIT      0
`define LANE_MSB         2
`define LANE_LSB         1
`define DEEMPH_EN_BIT    0

// ==========================================================================
// Reset values
`define CHIP_MODE_RST    8'h00
`define OUT_FORMAT_RST   8'h00
`define LANE_RATE_RST    8'h00
`define LINK_CTRL_RST    8'h01
`define DEEMPH_LVL_RST   4'h0

// ==========================================================================
// Timing
`define CLK_PERIOD_NS    10
`define PLL_SETTLE_NS    150
`define PLL_SETTLE_CYC   ((`PLL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/vc_map_pkg.sv
package vc_map_pkg;

    typedef enum logic [1:0]
    {
        MODE_FULL     = 2'b00,
        MODE_ONE_DDC  = 2'b01,
        MODE_TWO_DDC  = 2'b10,
        MODE_FOUR_DDC = 2'b11
    } op_mode_t;

    typedef enum logic
    {
        SER_IDLE = 1'b0,
        SER_SEND = 1'b1
    } ser_state_t;

    typedef logic [15:0]      sample_t;
    typedef sample_t [7:0]    slot_frame_t;

    typedef struct packed {
        logic [7:0]  chip_mode;
        logic [7:0]  out_format;
        logic [7:0]  lane_rate;
        logic [7:0]  link_ctrl;
        logic        deemph_en;
        logic [3:0]  deemph_lvl;
        op_mode_t    act_mode;
        logic        act_qign;
        logic [1:0]  act_lanes;
        logic [4:0]  settle;
        logic        pll_locked;
        logic [7:0]  rdata;
        ser_state_t  ser;
        slot_frame_t frame;
        logic [3:0]  last_idx;
        logic [3:0]  idx;
        logic [7:0]  octet;
        logic        oct_valid;
        logic        oct_last;
        logic [1:0]  lane;
    } mapper_state_t;

endpackage

// >>> rtl/frame_buffer.sv
`timescale 1ns/10ps
`default_nettype none

module frame_buffer #(
    parameter int WIDTH = 132,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output var  logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i,
    output var  logic [WIDTH-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               rd_ptr;
        logic [PW-1:0]               wr_ptr;
        logic [PW:0]                 count;
        logic                        in_ready;
        logic                        out_valid;
    } buf_state_t;

    buf_state_t cur;
    buf_state_t next_cur;
    logic       push;
    logic       pop;

    // ======================================================================
    // Storage and pointers
    always_comb
    begin
        next_cur = cur;
        push = in_valid_i && cur.in_ready;
        pop = cur.out_valid && out_ready_i;
        if (push)
        begin
            next_cur.mem[cur.wr_ptr] = in_data_i;
            next_cur.wr_ptr = PW'((32'(cur.wr_ptr) + 1) % DEPTH);
        end
        if (pop)
        begin
            next_cur.rd_ptr = PW'((32'(cur.rd_ptr) + 1) % DEPTH);
        end
        next_cur.count = cur.count + (PW+1)'(push) - (PW+1)'(pop);
        if (flush_i)
        begin
            next_cur.rd_ptr = '0;
            next_cur.wr_ptr = '0;
            next_cur.count = '0;
        end
        // Ready is a flop so the source sees full without a comb path
        next_cur.in_ready = (32'(next_cur.count) != DEPTH);
        next_cur.out_valid = (next_cur.count != '0);
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cur <= '0;
            cur.in_ready <= 1'b1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign in_ready_o = cur.in_ready;
    assign out_valid_o = cur.out_valid;
    assign out_data_o = cur.mem[cur.rd_ptr];

endmodule

`default_nettype wire

// >>> rtl/virtual_converter_mapper.sv
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none

`include "vc_map_cfg.svh"

// Overview of operation
// - Every sample stream gets its own slot
// - I in first slot, Q in next
// - Two ADCs match one complex downconverter count
// - Accept up to four downconverter inputs
// - Complex gives I and Q, real only I
// - Up to eight slots, count per mode
// - Mode field and Q-ignore select slot layout
// - Four complex downconverters fill slots in order
// - Twos complement after reset, format selectable
// - Serial outputs enabled after reset
// - De-emphasis off, set only by registers
// - PLL lock status read-only at bit seven
// - Pack mapped samples into eight-bit octets
// - Spread octets over one, two, four lanes
module virtual_converter_mapper
    import vc_map_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic [`ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_en_i,
    input  wire logic              rd_en_i,
    output logic      [7:0]        rdata_o,
    input  wire logic [15:0]       adc_a_i,
    input  wire logic [15:0]       adc_b_i,
    input  wire logic [3:0][15:0]  ddc_i_data_i,
    input  wire logic [3:0][15:0]  ddc_q_data_i,
    input  wire logic              sample_valid_i,
    output logic                   sample_ready_o,
    input  wire logic              pll_lock_i,
    output logic      [7:0]        octet_o,
    output logic                   octet_valid_o,
    output logic                   octet_last_o,
    output logic      [1:0]        lane_o,
    input  wire logic              octet_ready_i,
    output logic                   serdes_enable_o,
    output logic      [1:0]        lane_cfg_o,
    output logic                   low_rate_o,
    output logic                   deemph_en_o,
    output logic      [3:0]        deemph_level_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ======================================================================
    // Helpers
    function automatic sample_t fmt_word(input sample_t s, input logic ob);
        fmt_word = ob ? {~s[15], s[14:0]} : s;
    endfunction

    function automatic logic [3:0] slot_count(input op_mode_t m,
                                              input logic q);
        unique case (m)
            MODE_FULL:     slot_count = 4'h2;
            MODE_ONE_DDC:  slot_count = q ? 4'h1 : 4'h2;
            MODE_TWO_DDC:  slot_count = q ? 4'h2 : 4'h4;
            MODE_FOUR_DDC: slot_count = q ? 4'h4 : 4'h8;
        endcase
    endfunction

    function automatic slot_frame_t map_frame(
        input op_mode_t        m,
        input logic            q,
        input sample_t         a,
        input sample_t         b,
        input logic [3:0][15:0] di,
        input logic [3:0][15:0] dq,
        input logic            ob
    );
        slot_frame_t f;
        int          n;
        f = '0;
        n = (m == MODE_FULL) ? 0 : 1 << (int'(m) - 1);
        if (m == MODE_FULL)
        begin
            f[0] = a;
            f[1] = b;
        end
        // One, two or four converters; real keeps I only
        for (int k = 0; k < 4; k++)
        begin
            if (k < n && q)
            begin
                f[k] = di[k];
            end
            else if (k < n)
            begin
                f[2*k] = di[k];
                f[2*k+1] = dq[k];
            end
        end
        for (int k = 0; k < 8; k++)
        begin
            f[k] = fmt_word(f[k], ob);
        end
        map_frame = f;
    endfunction

    // Slot data goes out most significant octet first
    function automatic logic [7:0] octet_of(input slot_frame_t f,
                                            input logic [3:0] i);
        octet_of = i[0] ? f[i[3:1]][7:0] : f[i[3:1]][15:8];
    endfunction

    function automatic logic [1:0] lane_of(input logic [3:0] i,
                                           input logic [1:0] code);
        unique case (code)
            2'h0:    lane_of = 2'h0;
            2'h1:    lane_of = {1'b0, i[0]};
            default: lane_of = i[1:0];
        endcase
    endfunction

    // ======================================================================
    // State
    mapper_state_t  cur;
    mapper_state_t  next_cur;
    logic           link_down;
    logic           buf_in_valid;
    logic           buf_in_ready;
    logic [131:0]   buf_in_data;
    logic           buf_out_valid;
    logic           buf_out_ready;
    logic [131:0]   buf_out_data;
    logic           lane_rate_wr;

    assign link_down = !cur.link_ctrl[`LINK_EN_BIT];
    assign lane_rate_wr = wr_en_i && (addr_i == `REG_LANE_RATE);
    assign buf_in_valid = sample_valid_i && !link_down;
    assign buf_in_data = {slot_count(cur.act_mode, cur.act_qign),
        map_frame(cur.act_mode, cur.act_qign, adc_a_i, adc_b_i,
                  ddc_i_data_i, ddc_q_data_i,
                  cur.out_format[`FMT_BIT])};
    assign buf_out_ready = (cur.ser == SER_IDLE) && !link_down;

    // Two entries absorb a receiver stall; flushed on power down so no
    // frame of an old mapping survives into the next setup
    frame_buffer #(
        .WIDTH (132),
        .DEPTH (2)
    ) u_frame_buffer (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .flush_i     (link_down),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_data),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );

    always_comb
    begin
        next_cur = cur;
        // Register writes
        if (wr_en_i)
        begin
            unique case (addr_i)
                `REG_CHIP_MODE:  next_cur.chip_mode = wdata_i;
                `REG_OUT_FORMAT: next_cur.out_format = wdata_i;
                `REG_LANE_RATE:  next_cur.lane_rate = wdata_i;
                `REG_LINK_CTRL:  next_cur.link_ctrl = wdata_i;
                `REG_DEEMPH_EN:
                    next_cur.deemph_en = wdata_i[`DEEMPH_EN_BIT];
                `REG_DEEMPH_LVL: next_cur.deemph_lvl = wdata_i[3:0];
                default:         next_cur.rdata = cur.rdata;
            endcase
        end
        // Read data valid in the following cycle only
        next_cur.rdata = 8'h00;
        if (rd_en_i)
        begin
            unique case (addr_i)
                `REG_CHIP_MODE:  next_cur.rdata = cur.chip_mode;
                `REG_OUT_FORMAT: next_cur.rdata = cur.out_format;
                `REG_LANE_RATE:  next_cur.rdata = cur.lane_rate;
                `REG_PLL_STATUS:
                    next_cur.rdata = {cur.pll_locked, 7'h00};
                `REG_LINK_CTRL:  next_cur.rdata = cur.link_ctrl;
                `REG_DEEMPH_EN:  next_cur.rdata = {7'h00, cur.deemph_en};
                `REG_DEEMPH_LVL: next_cur.rdata = {4'h0, cur.deemph_lvl};
                default:         next_cur.rdata = 8'h00;
            endcase
        end
        // Mapping is only taken over while the link is down
        if (link_down)
        begin
            next_cur.act_mode =
                op_mode_t'(cur.chip_mode[`MODE_MSB:`MODE_LSB]);
            next_cur.act_qign = cur.chip_mode[`QIGN_BIT];
            next_cur.act_lanes = cur.link_ctrl[`LANE_MSB:`LANE_LSB];
        end
        // Lock counts only for the current lane-rate setting
        if (!pll_lock_i || lane_rate_wr)
        begin
            next_cur.settle = 5'h00;
        end
        else if (cur.settle != 5'(`PLL_SETTLE_CYC))
        begin
            next_cur.settle = cur.settle + 5'h01;
        end
        next_cur.pll_locked = pll_lock_i && !lane_rate_wr &&
            (cur.settle == 5'(`PLL_SETTLE_CYC));
        // Octet serializer
        if (link_down)
        begin
            next_cur.ser = SER_IDLE;
            next_cur.oct_valid = 1'b0;
            next_cur.oct_last = 1'b0;
        end
        else if (cur.ser == SER_IDLE)
        begin
            if (buf_out_valid)
            begin
                next_cur.frame = buf_out_data[127:0];
                next_cur.last_idx = 4'((buf_out_data[131:128] << 1) - 4'h1);
                next_cur.idx = 4'h0;
                next_cur.octet = octet_of(buf_out_data[127:0], 4'h0);
                next_cur.oct_valid = 1'b1;
                next_cur.oct_last = 1'b0;
                next_cur.lane = 2'h0;
                next_cur.ser = SER_SEND;
            end
        end
        else if (octet_ready_i)
        begin
            if (cur.idx == cur.last_idx)
            begin
                next_cur.ser = SER_IDLE;
                next_cur.oct_valid = 1'b0;
                next_cur.oct_last = 1'b0;
            end
            else
            begin
                next_cur.idx = cur.idx + 4'h1;
                next_cur.octet = octet_of(cur.frame, next_cur.idx);
                next_cur.lane = lane_of(next_cur.idx, cur.act_lanes);
                next_cur.oct_last = (next_cur.idx == cur.last_idx);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cur <= '0;
            cur.chip_mode <= `CHIP_MODE_RST;
            cur.out_format <= `OUT_FORMAT_RST;
            cur.lane_rate <= `LANE_RATE_RST;
            cur.link_ctrl <= `LINK_CTRL_RST;
            cur.deemph_en <= 1'b0;
            cur.deemph_lvl <= `DEEMPH_LVL_RST;
            cur.act_mode <= MODE_FULL;
            cur.ser <= SER_IDLE;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rdata_o = cur.rdata;
    assign sample_ready_o = buf_in_ready;
    assign octet_o = cur.octet;
    assign octet_valid_o = cur.oct_valid;
    assign octet_last_o = cur.oct_last;
    assign lane_o = cur.lane;
    assign serdes_enable_o = cur.link_ctrl[`LINK_EN_BIT];
    assign lane_cfg_o = cur.act_lanes;
    assign low_rate_o = cur.lane_rate[`LOW_RATE_BIT];
    assign deemph_en_o = cur.deemph_en;
    assign deemph_level_o = cur.deemph_lvl;

    // ======================================================================
    // Checks
    a_iq_pair_order: assert property (
        buf_in_valid && cur.act_mode == MODE_ONE_DDC && !cur.act_qign
        |-> buf_in_data[31:16] ==
            fmt_word(ddc_q_data_i[0], cur.out_format[`FMT_BIT]))
        else $error("Q sample not in slot after I");
    a_four_ddc_order: assert property (
        buf_in_valid && cur.act_mode == MODE_FOUR_DDC && !cur.act_qign
        |-> buf_in_data[127:112] ==
            fmt_word(ddc_q_data_i[3], cur.out_format[`FMT_BIT])
            && buf_in_data[79:64] ==
            fmt_word(ddc_i_data_i[2], cur.out_format[`FMT_BIT]))
        else $error("Four converter slot order wrong");
    a_unused_zero: assert property (
        buf_in_valid && cur.act_mode == MODE_TWO_DDC && cur.act_qign
        |-> buf_in_data[127:32] == '0 && buf_in_data[131:128] == 4'h2)
        else $error("Real mode filled unused slots");
    a_full_bw_count: assert property (
        buf_in_valid && cur.act_mode == MODE_FULL
        |-> buf_in_data[131:128] == 4'h2)
        else $error("Full bandwidth slot count wrong");
    a_twos_default: assert property (
        buf_in_valid && cur.act_mode == MODE_FULL && !cur.out_format[0]
        |-> buf_in_data[15:0] == adc_a_i)
        else $error("Default format not twos complement");
    a_power_default: assert property (
        $rose(rstn_i) |-> serdes_enable_o)
        else $error("Outputs not enabled after reset");
    a_deemph_write: assert property (
        $changed(deemph_en_o)
        |-> $past(wr_en_i) && $past(addr_i) == `REG_DEEMPH_EN)
        else $error("De-emphasis changed without write");
    a_lock_drop: assert property (
        lane_rate_wr |=> (!cur.pll_locked) [*8])
        else $error("Lock reported before resettle");
    a_map_frozen: assert property (
        !link_down && !$past(link_down)
        |-> $stable(cur.act_mode) && $stable(cur.act_qign))
        else $error("Mapping changed while link up");
    a_octet_hold: assert property (
        octet_valid_o && !octet_ready_i && serdes_enable_o
        |=> octet_valid_o && $stable(octet_o))
        else $error("Octet dropped under stall");
    a_lane_range: assert property (
        octet_valid_o && lane_cfg_o == 2'h1 |-> lane_o[1] == 1'b0)
        else $error("Lane outside configured count");

endmodule

`default_nettype wire

// >>> tb/link_rx_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Link layer stand-in: records every accepted octet
module link_rx_model (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       stall_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] octet_i,
    input  wire logic       valid_i,
    input  wire logic       last_i,
    input  wire logic [1:0] lane_i,
    output var  logic       ready_o
);
    logic [7:0] rx [0:255];
    logic       rx_last [0:255];
    logic [1:0] rx_lane [0:255];
    int         cnt;
    logic       tog;

    // Slow mode accepts only every other cycle
    assign ready_o = !stall_i && (!slow_i || tog);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt <= 0;
            tog <= 1'b0;
        end
        else
        begin
            tog <= !tog;
            if (valid_i && ready_o)
            begin
                rx[cnt[7:0]] <= octet_i;
                rx_last[cnt[7:0]] <= last_i;
                rx_lane[cnt[7:0]] <= lane_i;
                cnt <= cnt + 1;
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb/virtual_converter_mapper_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define chk(n, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("ERROR %s exp %h got %h", n, e, g); \
        end \
    end

module virtual_converter_mapper_tb;
    import vc_map_pkg::*;

    logic             clk_i, rstn_i, wr_en_i, rd_en_i, pll_lock_i;
    logic [11:0]      addr_i;
    logic [7:0]       wdata_i, rdata_o, octet_o;
    logic [15:0]      adc_a, adc_b;
    logic [3:0][15:0] di, dq;
    logic             vld, s_rdy, o_vld, o_last, o_rdy, ser_en;
    logic             low_rate, de_en, stall, slow;
    logic [1:0]       lane, lane_cfg;
    logic [3:0]       de_lvl;
    int               mismatches, check_count;

    virtual_converter_mapper DUT (.clk_i(clk_i), .rstn_i(rstn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .rdata_o(rdata_o), .adc_a_i(adc_a),
        .adc_b_i(adc_b), .ddc_i_data_i(di), .ddc_q_data_i(dq),
        .sample_valid_i(vld), .sample_ready_o(s_rdy),
        .pll_lock_i(pll_lock_i), .octet_o(octet_o),
        .octet_valid_o(o_vld), .octet_last_o(o_last), .lane_o(lane),
        .octet_ready_i(o_rdy), .serdes_enable_o(ser_en),
        .lane_cfg_o(lane_cfg), .low_rate_o(low_rate),
        .deemph_en_o(de_en), .deemph_level_o(de_lvl));

    link_rx_model rxm (.clk_i(clk_i), .rstn_i(rstn_i), .stall_i(stall),
        .slow_i(slow), .octet_i(octet_o), .valid_i(o_vld),
        .last_i(o_last), .lane_i(lane), .ready_o(o_rdy));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic test_done();
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ======================================================================
    // Register bus
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `chk("reg", e, d)
    endtask

    // ======================================================================
    // Sample path
    function automatic logic [15:0] exp_w(int m, int q, int k, logic f);
        logic [15:0] w;
        if (m == 0)
            w = k ? adc_b : adc_a;
        else if (q)
            w = di[k];
        else
            w = k[0] ? dq[k/2] : di[k/2];
        return f ? {~w[15], w[14:0]} : w;
    endfunction

    function automatic int nsl(int m, int q);
        return m == 0 ? 2 : (q ? 1 : 2) << (m - 1);
    endfunction

    task automatic wait_rx(int t);
        int w;
        w = 0;
        while (rxm.cnt < t && w < 400)
        begin
            @(posedge clk_i);
            w++;
        end
        if (rxm.cnt < t)
        begin
            `chk("timeout", t, rxm.cnt)
            test_done();
        end
        repeat (4) @(posedge clk_i);
        `chk("count", t, rxm.cnt)
    endtask

    task automatic send_set();
        int   w;
        logic r;
        w = 0;
        @(posedge clk_i);
        vld <= 1'b1;
        // Ready taken before the edge, as the design samples it
        do
        begin
            #1 r = s_rdy;
            @(posedge clk_i);
            w++;
        end
        while (!r && w < 50);
        vld <= 1'b0;
        if (!r)
        begin
            `chk("send", 1'b1, r)
            test_done();
        end
    endtask

    task automatic get_frame(int m, int q, logic f, int lc);
        int n, b, nl;
        logic [15:0] e;
        n = 2 * nsl(m, q);
        nl = 1 << (lc > 1 ? 2 : lc);
        b = rxm.cnt;
        send_set();
        wait_rx(b + n);
        for (int i = 0; i < n; i++)
        begin
            e = exp_w(m, q, i / 2, f);
            `chk("octet", i[0] ? e[7:0] : e[15:8], rxm.rx[b+i])
            `chk("lane", 2'(i % nl), rxm.rx_lane[b+i])
        end
        `chk("last", 1'b1, rxm.rx_last[b+n-1])
    endtask

    task automatic cfg(int m, int q, logic f, int lc);
        wr(12'h5B0, 8'(lc << 1));
        wr(12'h200, 8'((q << 5) | m));
        wr(12'h561, {7'h00, f});
        wr(12'h5B0, 8'((lc << 1) | 1));
        repeat (2) @(posedge clk_i);
        `chk("lanes", 2'(lc), lane_cfg)
        `chk("enable", 1'b1, ser_en)
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        `chk("enable", 1'b1, ser_en)
        `chk("de_en", 1'b0, de_en)
        `chk("de_lvl", 4'h0, de_lvl)
        rchk(12'h200, 8'h00);
        rchk(12'h561, 8'h00);
        rchk(12'h56E, 8'h00);
        rchk(12'h5B0, 8'h01);
        rchk(12'h56F, 8'h00);
        rchk(12'h123, 8'h00);
    endtask

    task automatic t_pll();
        logic [7:0] d;
        @(posedge clk_i);
        pll_lock_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        wr(12'h56F, 8'h00);
        rd(12'h56F, d);
        `chk("lock", 1'b1, d[7])
        wr(12'h56E, 8'h10);
        rd(12'h56F, d);
        `chk("relock", 1'b0, d[7])
        `chk("low_rate", 1'b1, low_rate)
        repeat (20) @(posedge clk_i);
        rd(12'h56F, d);
        `chk("lock", 1'b1, d[7])
    endtask

    task automatic t_deemph();
        wr(12'h5C1, 8'h01);
        wr(12'h5C5, 8'h07);
        @(posedge clk_i);
        `chk("de_en", 1'b1, de_en)
        `chk("de_lvl", 4'h7, de_lvl)
        rchk(12'h5C5, 8'h07);
    endtask

    task automatic t_map();
        for (int m = 0; m < 4; m++)
            for (int q = 0; q < 2; q++)
            begin
                cfg(m, q, m == 3 && q == 0, (m + q) % 3);
                get_frame(m, q, m == 3 && q == 0, (m + q) % 3);
            end
    endtask

    task automatic t_hold();
        cfg(0, 0, 1'b0, 0);
        wr(12'h200, 8'h03);
        get_frame(0, 0, 1'b0, 0);
    endtask

    task automatic t_buffer();
        int acc, b;
        b = rxm.cnt;
        acc = 0;
        stall <= 1'b1;
        @(posedge clk_i);
        vld <= 1'b1;
        // Two buffer entries plus the frame held by the serializer
        repeat (8)
        begin
            #1 acc += s_rdy;
            @(posedge clk_i);
        end
        vld <= 1'b0;
        `chk("full", 1'b0, s_rdy)
        `chk("accepted", 3, acc)
        slow <= 1'b1;
        stall <= 1'b0;
        wait_rx(b + 4 * acc);
        `chk("ready", 1'b1, s_rdy)
    endtask

    initial
    begin
        rstn_i = 1'b0;
        {wr_en_i, rd_en_i, vld, pll_lock_i, stall, slow} = '0;
        addr_i = 12'h000;
        wdata_i = 8'h00;
        adc_a = 16'hC3A5;
        adc_b = 16'h1234;
        for (int k = 0; k < 4; k++)
        begin
            di[k] = 16'hA011 | (16'(k) << 8);
            dq[k] = 16'h5022 | (16'(k) << 8);
        end
        mismatches = 0;
        check_count = 0;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_pll();
        t_deemph();
        t_map();
        t_hold();
        t_buffer();
        test_done();
    end
endmodule

`default_nettype wire
